// file: include/ptc_consts.vh
// constants for the trigger and timestamp control block
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH
`define PTC_OFF_TRIG_SEQ       12'h540
`define PTC_OFF_CASC_INTERVAL  12'h544
`define PTC_OFF_PULSE_LEN      12'h548
`define PTC_OFF_TS_STAT        12'h550
`define PTC_OFF_UNIT_SEL       12'h560
`define PTC_OFF_TRIG_CTRL      12'h564
`define PTC_OFF_TRIG_TARGET    12'h568
`define PTC_OFF_CYCLE_WIDTH    12'h56C
`define PTC_CYC_CNT_HI         31
`define PTC_CYC_CNT_LO         16
`define PTC_PAT_HI             15
`define PTC_PAT_LO             0
`define PTC_PPS_HI             23
`define PTC_PPS_LO             16
`define PTC_PW_HI              15
`define PTC_PW_LO              0
`define PTC_CNT_HI             20
`define PTC_CNT_LO             17
`define PTC_OVF_BIT            16
`define PTC_RISE_BIT           7
`define PTC_FALL_BIT           6
`define PTC_LAST_BIT           5
`define PTC_UPSEL_BIT          1
`define PTC_JOIN_BIT           0
`define PTC_CNT_MAX            4'hF
`define PTC_MODE_PATTERN       3'h6
`define PTC_MODE_PULSE_POS     3'h5
`define PTC_MODE_PULSE_NEG     3'h4
`define PTC_CLK_PERIOD_PS      4000
`define PTC_NS_STEP_PS         1000
`define PTC_PW_STEP_PS         8000
`define PTC_NS_INC             ((`PTC_CLK_PERIOD_PS) / (`PTC_NS_STEP_PS))
`define PTC_PW_STEP_CYC        ((`PTC_PW_STEP_PS) / (`PTC_CLK_PERIOD_PS))
`define PTC_EVT_MAX_MHZ        25
`define PTC_RST_ZERO32         32'h00000000
`endif

// file: src/ptc_trig_ts_ctrl.v
// trigger output and timestamp input control with apb registers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "ptc_consts.vh"

// What this block does
// - unit index selects trigger register instance
// - cycle count bits 31:16, zero repeats forever
// - bits 15:0 hold shifted bit pattern
// - cascade adds interval to target time
// - interval counted in one nanosecond steps
// - bits 23:16 extend pulse width upward
// - pulse width counted in 8 ns steps
// - read-only edge count at bits 20:17
// - single mode records up to fifteen events
// - edges detected at rates up to 25 MHz
// - overflow flag bit 16, zero until overflow
// - in cascade only tail sets overflow
// - count saturates at fifteen after overflow
// - bit 7 enables rising edge detection
// - bit 6 enables falling edge detection
// - bit 5 marks last unit of chain
// - bit 1 picks upstream done source unit
// - bit 0 joins unit into cascade
// - mode 110 drives output from pattern
// - cycle width sets period in ns steps
module ptc_trig_ts_ctrl #(
  parameter N_TRIG = 4,
  parameter N_TS   = 2
) (
  // clock and reset
  input  wire               ref_clk_i,
  input  wire               rst_n_i,
  // apb slave
  input  wire               psel_i,
  input  wire               penable_i,
  input  wire               pwrite_i,
  input  wire [11:0]        paddr_i,
  input  wire [31:0]        pwdata_i,
  output reg  [31:0]        prdata_o,
  output reg                pready_o,
  output reg                pslverr_o,
  // event inputs and trigger outputs
  input  wire [N_TS-1:0]    evt_in_i,
  output reg  [N_TRIG-1:0]  trig_out_o
);

  // apb decode
  wire        acc     = psel_i & penable_i & ~pready_o;
  wire        wr      = acc & pwrite_i;
  wire        hit_seq = paddr_i == `PTC_OFF_TRIG_SEQ;
  wire        hit_civ = paddr_i == `PTC_OFF_CASC_INTERVAL;
  wire        hit_pl  = paddr_i == `PTC_OFF_PULSE_LEN;
  wire        hit_ts  = paddr_i == `PTC_OFF_TS_STAT;
  wire        hit_sel = paddr_i == `PTC_OFF_UNIT_SEL;
  wire        hit_tc  = paddr_i == `PTC_OFF_TRIG_CTRL;
  wire        hit_tt  = paddr_i == `PTC_OFF_TRIG_TARGET;
  wire        hit_cw  = paddr_i == `PTC_OFF_CYCLE_WIDTH;
  wire        hit_any = hit_seq | hit_civ | hit_pl | hit_ts | hit_sel | hit_tc | hit_tt | hit_cw;

  // global unit index: trigger [1:0], timestamp [8]
  reg  [1:0]  trig_sel_reg;
  reg         ts_sel_reg;
  // free-running nanosecond time base
  reg  [31:0] now_ns_reg;

  // per trigger unit storage
  reg  [31:0] seq_reg      [0:N_TRIG-1];
  reg  [31:0] civ_reg      [0:N_TRIG-1];
  reg  [23:0] pl_reg       [0:N_TRIG-1];
  reg  [3:0]  tctl_reg     [0:N_TRIG-1];
  reg  [31:0] target_reg   [0:N_TRIG-1];
  reg  [31:0] cyc_w_reg    [0:N_TRIG-1];
  // per timestamp unit storage
  reg  [3:0]  cnt_reg      [0:N_TS-1];
  reg         ovf_reg      [0:N_TS-1];
  reg  [4:0]  tsctl_reg    [0:N_TS-1];
  reg         evt_d_reg    [0:N_TS-1];
  reg         done_reg     [0:N_TS-1];

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_sel_reg <= 2'h0;
      ts_sel_reg   <= 1'h0;
      now_ns_reg   <= `PTC_RST_ZERO32;
    end else begin
      now_ns_reg <= now_ns_reg + `PTC_NS_INC;
      if (wr && hit_sel) begin
        trig_sel_reg <= pwdata_i[1:0];
        ts_sel_reg   <= pwdata_i[8];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_TRIG; g = g + 1) begin : g_trig
      // tctl: [0] enable, [3:1] waveform mode
      wire        sel_me = trig_sel_reg == g;
      wire [2:0]  mode   = tctl_reg[g][3:1];
      wire [31:0] pw_cyc = {8'h00, pl_reg[g]} * `PTC_PW_STEP_CYC;
      wire [31:0] cyc_cy = cyc_w_reg[g] / `PTC_NS_INC;
      reg  [31:0] ph_reg;
      reg  [15:0] done_cyc_reg;
      reg  [3:0]  bit_reg;
      reg         run_reg;
      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          seq_reg[g]    <= `PTC_RST_ZERO32;
          civ_reg[g]    <= `PTC_RST_ZERO32;
          pl_reg[g]     <= 24'h000000;
          tctl_reg[g]   <= 4'h0;
          target_reg[g] <= `PTC_RST_ZERO32;
          cyc_w_reg[g]  <= `PTC_RST_ZERO32;
          ph_reg        <= `PTC_RST_ZERO32;
          done_cyc_reg  <= 16'h0000;
          bit_reg       <= 4'h0;
          run_reg       <= 1'b0;
          trig_out_o[g] <= 1'b0;
        end else begin
          if (wr && sel_me) begin
            if (hit_seq) seq_reg[g] <= pwdata_i;
            if (hit_civ) civ_reg[g] <= pwdata_i;
            if (hit_pl) pl_reg[g] <= pwdata_i[`PTC_PPS_HI:`PTC_PW_LO];
            if (hit_tc) tctl_reg[g] <= pwdata_i[3:0];
            if (hit_tt) target_reg[g] <= pwdata_i;
            if (hit_cw) cyc_w_reg[g] <= pwdata_i;
          end
          if (!run_reg) begin
            if (tctl_reg[g][0] && now_ns_reg == target_reg[g]) begin
              run_reg      <= 1'b1;
              ph_reg       <= `PTC_RST_ZERO32;
              done_cyc_reg <= 16'h0000;
              bit_reg      <= 4'h0;
            end
          end else if (!tctl_reg[g][0]) begin
            run_reg <= 1'b0;
          end else if (mode == `PTC_MODE_PATTERN) begin
            trig_out_o[g] <= seq_reg[g][bit_reg];
            if (ph_reg + 32'h1 >= pw_cyc) begin
              ph_reg  <= `PTC_RST_ZERO32;
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'hF) begin
                done_cyc_reg <= done_cyc_reg + 16'h1;
                if (seq_reg[g][`PTC_CYC_CNT_HI:`PTC_CYC_CNT_LO] != 16'h0000 &&
                    done_cyc_reg + 16'h1 == seq_reg[g][`PTC_CYC_CNT_HI:`PTC_CYC_CNT_LO]) begin
                  run_reg       <= 1'b0;
                  target_reg[g] <= target_reg[g] + civ_reg[g];
                end
              end
            end else begin
              ph_reg <= ph_reg + 32'h1;
            end
          end else begin
            // pulse inside each period of cycle width
            trig_out_o[g] <= (ph_reg < pw_cyc) ^ (mode == `PTC_MODE_PULSE_NEG);
            if (ph_reg + 32'h1 >= cyc_cy) begin
              ph_reg       <= `PTC_RST_ZERO32;
              done_cyc_reg <= done_cyc_reg + 16'h1;
              if (seq_reg[g][`PTC_CYC_CNT_HI:`PTC_CYC_CNT_LO] != 16'h0000 &&
                  done_cyc_reg + 16'h1 == seq_reg[g][`PTC_CYC_CNT_HI:`PTC_CYC_CNT_LO]) begin
                run_reg       <= 1'b0;
                target_reg[g] <= target_reg[g] + civ_reg[g];
              end
            end else begin
              ph_reg <= ph_reg + 32'h1;
            end
          end
        end
      end
    end

    for (g = 0; g < N_TS; g = g + 1) begin : g_ts
      wire sel_me = ts_sel_reg == g;
      wire rise   = evt_in_i[g] & ~evt_d_reg[g];
      wire fall   = ~evt_in_i[g] & evt_d_reg[g];
      // edges sampled every clock, well above 25 MHz
      wire hit    = (rise & tsctl_reg[g][4]) | (fall & tsctl_reg[g][3]);
      wire up_done = done_reg[tsctl_reg[g][1]];
      wire chained = tsctl_reg[g][0];
      wire is_last = tsctl_reg[g][2];
      wire may_ovf = ~chained | is_last;
      wire clr     = wr && sel_me && hit_ts;
      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cnt_reg[g]   <= 4'h0;
          ovf_reg[g]   <= 1'b0;
          tsctl_reg[g] <= 5'h00;
          evt_d_reg[g] <= 1'b0;
          done_reg[g]  <= 1'b0;
        end else begin
          evt_d_reg[g] <= evt_in_i[g];
          if (clr) begin
            tsctl_reg[g] <= {pwdata_i[`PTC_RISE_BIT], pwdata_i[`PTC_FALL_BIT],
                             pwdata_i[`PTC_LAST_BIT], pwdata_i[`PTC_UPSEL_BIT],
                             pwdata_i[`PTC_JOIN_BIT]};
          end
          // in cascade, arm only after upstream unit is done; unit 0 always arms
          if (hit && (!chained || up_done || g == 0)) begin
            if (cnt_reg[g] == `PTC_CNT_MAX) begin
              if (may_ovf) ovf_reg[g] <= 1'b1;
              if (chained) done_reg[g] <= 1'b1;
            end else begin
              cnt_reg[g] <= cnt_reg[g] + 4'h1;
            end
          end
        end
      end
    end
  endgenerate

  // read mux
  reg [31:0] rd;
  always @* begin
    rd = `PTC_RST_ZERO32;
    if (hit_seq) rd = seq_reg[trig_sel_reg];
    if (hit_civ) rd = civ_reg[trig_sel_reg];
    if (hit_pl)  rd = {8'h00, pl_reg[trig_sel_reg]};
    if (hit_tc)  rd = {28'h0000000, tctl_reg[trig_sel_reg]};
    if (hit_tt)  rd = target_reg[trig_sel_reg];
    if (hit_cw)  rd = cyc_w_reg[trig_sel_reg];
    if (hit_sel) rd = {23'h000000, ts_sel_reg, 6'h00, trig_sel_reg};
    if (hit_ts) begin
      rd[`PTC_CNT_HI:`PTC_CNT_LO] = cnt_reg[ts_sel_reg];
      rd[`PTC_OVF_BIT]   = ovf_reg[ts_sel_reg];
      rd[`PTC_RISE_BIT]  = tsctl_reg[ts_sel_reg][4];
      rd[`PTC_FALL_BIT]  = tsctl_reg[ts_sel_reg][3];
      rd[`PTC_LAST_BIT]  = tsctl_reg[ts_sel_reg][2];
      rd[`PTC_UPSEL_BIT] = tsctl_reg[ts_sel_reg][1];
      rd[`PTC_JOIN_BIT]  = tsctl_reg[ts_sel_reg][0];
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o  <= `PTC_RST_ZERO32;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= acc;
      pslverr_o <= acc & ~hit_any;
      if (acc && !pwrite_i) prdata_o <= rd;
    end
  end

endmodule

// file: bench/ptc_props.sv
// port assertions for the trigger and timestamp control block
`timescale 1ns/1ps
`include "ptc_consts.vh"
module ptc_props #(
  parameter N_TRIG = 4,
  parameter N_TS   = 2
) (
  input wire              ref_clk_i,
  input wire              rst_n_i,
  input wire              psel_i,
  input wire              penable_i,
  input wire              pwrite_i,
  input wire [11:0]       paddr_i,
  input wire [31:0]       pwdata_i,
  input wire [31:0]       prdata_o,
  input wire              pready_o,
  input wire              pslverr_o,
  input wire [N_TS-1:0]   evt_in_i,
  input wire [N_TRIG-1:0] trig_out_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire rd  = pready_o && !pwrite_i;
  wire hit = paddr_i inside {12'h540, 12'h544, 12'h548, 12'h550,
                             12'h560, 12'h564, 12'h568, 12'h56C};
  wire ts  = rd && paddr_i == `PTC_OFF_TS_STAT;
  property p_ans;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer to access");
  property p_one;
    pready_o |=> !pready_o;
  endproperty
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  property p_err;
    pslverr_o |-> pready_o && !hit;
  endproperty
  a_err: assert property (p_err) else $error("error on mapped place");
  property p_unm;
    pready_o && !hit |-> pslverr_o && (pwrite_i || prdata_o == 32'h0);
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped access not refused");
  property p_hold;
    !(psel_i && penable_i && !pwrite_i) |=> $stable(prdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_rsv_ts;
    ts |-> (prdata_o & 32'hFFE0FF1C) == 32'h0;
  endproperty
  a_rsv_ts: assert property (p_rsv_ts) else $error("status reserved bits set");
  property p_rsv_pl;
    rd && paddr_i == `PTC_OFF_PULSE_LEN |-> prdata_o[31:24] == 8'h00;
  endproperty
  a_rsv_pl: assert property (p_rsv_pl) else $error("pulse reserved bits set");
  property p_sat;
    ts && prdata_o[16] |-> prdata_o[20:17] == 4'hF;
  endproperty
  a_sat: assert property (p_sat) else $error("count not held at fifteen");
  c_ovf: cover property (ts && prdata_o[16]);
  c_unm: cover property (pslverr_o);
  c_trig: cover property (trig_out_o != '0);
endmodule
bind ptc_trig_ts_ctrl ptc_props #(.N_TRIG(N_TRIG), .N_TS(N_TS)) u_props (
  .ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .evt_in_i, .trig_out_o);

// file: bench/ptc_evt_src.sv
// event source standing at the timestamp inputs
`timescale 1ns/1ps
module ptc_evt_src #(
  parameter N = 2
) (
  input  wire          ref_clk_i,
  output logic [N-1:0] evt_o
);
  initial evt_o = '0;
  // toggle one input n times, edges spaced six clocks (24 ns) apart
  task automatic edges(input int u, input int n);
    repeat (n) begin
      repeat (6) @(posedge ref_clk_i);
      evt_o[u] <= ~evt_o[u];
    end
  endtask
endmodule

// file: bench/testbench.sv
// self-checking bench for the trigger and timestamp control block
`timescale 1ns/1ps
`include "ptc_consts.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  wire  [31:0] prdata_o;
  wire         pready_o;
  wire         pslverr_o;
  wire  [1:0]  evt_in_i;
  wire  [3:0]  trig_out_o;
  logic [31:0] rd_v;
  logic        er_v;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  ptc_trig_ts_ctrl dut (.ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .evt_in_i, .trig_out_o);
  ptc_evt_src ev (.ref_clk_i, .evt_o(evt_in_i));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  // one apb transfer, held until ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (n >= 40) err_total++;
    rd_v = prdata_o;
    er_v = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, e, rd_v)
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rchk("seq", `PTC_OFF_TRIG_SEQ, 32'h0);
    rchk("ivl", `PTC_OFF_CASC_INTERVAL, 32'h0);
    rchk("plen", `PTC_OFF_PULSE_LEN, 32'h0);
    rchk("ts", `PTC_OFF_TS_STAT, 32'h0);
    $display("test reset done");
    xfer(1'b1, `PTC_OFF_UNIT_SEL, 32'h1);
    xfer(1'b1, `PTC_OFF_TRIG_SEQ, 32'h0003A5C3);
    xfer(1'b1, `PTC_OFF_UNIT_SEL, 32'h0);
    xfer(1'b1, `PTC_OFF_TRIG_SEQ, 32'hFFFF0000);
    rchk("seq0", `PTC_OFF_TRIG_SEQ, 32'hFFFF0000);
    xfer(1'b1, `PTC_OFF_UNIT_SEL, 32'h1);
    rchk("seq1", `PTC_OFF_TRIG_SEQ, 32'h0003A5C3);
    xfer(1'b1, `PTC_OFF_CASC_INTERVAL, 32'hFFFFFFFF);
    rchk("ivl", `PTC_OFF_CASC_INTERVAL, 32'hFFFFFFFF);
    xfer(1'b1, `PTC_OFF_PULSE_LEN, 32'hFFFFFFFF);
    rchk("plen", `PTC_OFF_PULSE_LEN, 32'h00FFFFFF);
    xfer(1'b1, 12'h5F0, 32'hFFFFFFFF);
    `CHK("werr", 1'b1, er_v)
    rchk("unm", 12'h5F0, 32'h0);
    `CHK("rerr", 1'b1, er_v)
    $display("test regs done");
    xfer(1'b1, `PTC_OFF_UNIT_SEL, 32'h0);
    xfer(1'b1, `PTC_OFF_TS_STAT, 32'h80);
    ev.edges(0, 4);
    rchk("rise", `PTC_OFF_TS_STAT, 32'h00040080);
    xfer(1'b1, `PTC_OFF_TS_STAT, 32'h40);
    ev.edges(0, 2);
    rchk("fall", `PTC_OFF_TS_STAT, 32'h00060040);
    xfer(1'b1, `PTC_OFF_TS_STAT, 32'h0);
    ev.edges(0, 2);
    rchk("off", `PTC_OFF_TS_STAT, 32'h00060000);
    xfer(1'b1, `PTC_OFF_TS_STAT, 32'hC0);
    ev.edges(0, 12);
    rchk("full", `PTC_OFF_TS_STAT, 32'h001E00C0);
    ev.edges(0, 2);
    rchk("ovf", `PTC_OFF_TS_STAT, 32'h001F00C0);
    xfer(1'b1, `PTC_OFF_UNIT_SEL, 32'h100);
    xfer(1'b1, `PTC_OFF_TS_STAT, 32'hFFFFFFFF);
    rchk("ts1", `PTC_OFF_TS_STAT, 32'h000000E3);
    xfer(1'b1, `PTC_OFF_TS_STAT, 32'hC1);
    ev.edges(1, 2);
    rchk("chain", `PTC_OFF_TS_STAT, 32'h000000C1);
    $display("test events done");
    xfer(1'b1, `PTC_OFF_UNIT_SEL, 32'h0);
    xfer(1'b1, `PTC_OFF_TRIG_SEQ, 32'h0001FFFF);
    xfer(1'b1, `PTC_OFF_PULSE_LEN, 32'h1);
    xfer(1'b1, `PTC_OFF_TRIG_TARGET, 32'h00004000);
    xfer(1'b1, `PTC_OFF_TRIG_CTRL, 32'hD);
    for (int i = 0; i < 6000 && trig_out_o[0] !== 1'b1; i++) @(posedge ref_clk_i);
    `CHK("pat", 1'b1, trig_out_o[0])
    $display("test pattern done");
    end_sim();
  end
endmodule
